// >>> core/dac_seq_pkg.sv
// Package for the DAC update sequencer: register map, command layout,
// word defaults and timing counts.
// Assumes a 250 MHz core clock and a 32-bit APB register bus.
package dac_seq_pkg;

    // ==========================================================
    // Clock and sequence timing
    localparam int CLK_PERIOD_NS  = 4;
    localparam int POR_TIME_MS    = 8;
    localparam int RST_MIN_US     = 70;
    localparam int RST_MAX_US     = 120;
    localparam int POR_CYCLES     = POR_TIME_MS * 1000000 / CLK_PERIOD_NS;
    // Least time rounds up
    localparam int RST_CYCLES     = (RST_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Channel geometry
    localparam int NUM_CHANNELS   = 40;
    localparam int NUM_GROUPS     = 4;
    localparam int GROUP_SIZE     = 10;
    localparam int FIFO_DEPTH     = 128;
    localparam int FIFO_AW        = 7;

    // ==========================================================
    // Word defaults and limits
    localparam logic [13:0] INPUT_DEFAULT   = 14'h2000;
    localparam logic [13:0] OFFSET_DEFAULT  = 14'h2000;
    localparam logic [12:0] GAIN_DEFAULT    = 13'h1FFF;
    localparam logic [13:0] COMPUTED_DEFAULT = 14'h2000;
    localparam logic [13:0] FULL_SCALE      = 14'h3FFF;
    localparam logic [13:0] SOFT_RESET_CODE = 14'h3FFF;
    localparam logic [16:0] OFFSET_MID      = 17'h02000;

    // ==========================================================
    // Destination select codes
    typedef enum logic [1:0] {
        DEST_SPECIAL = 2'b00,
        DEST_GAIN    = 2'b01,
        DEST_OFFSET  = 2'b10,
        DEST_INPUT   = 2'b11
    } dest_t;

    // Special function fields
    localparam int STEP_LSB      = 0;
    localparam int STEP_WIDTH    = 7;
    localparam int STEP_DIR_BIT  = 8;

    // Command word as written to the command register
    typedef struct packed {
        dest_t       dest_select;
        logic [7:0]  channel_select_bus;
        logic [13:0] write_data_bus;
    } cmd_t;

    // ==========================================================
    // APB register map (byte addresses)
    localparam logic [7:0] REG_CMD       = 8'h00;
    localparam logic [7:0] REG_CTRL      = 8'h04;
    localparam logic [7:0] REG_STATUS    = 8'h08;
    localparam logic [7:0] REG_CHAN_SEL  = 8'h0C;
    localparam logic [7:0] REG_CHAN_DATA = 8'h10;

    localparam int CTRL_FIFO_EN_BIT    = 0;
    localparam logic CTRL_FIFO_EN_RESET = 1'b1;

    localparam int ST_BUSY_BIT     = 0;
    localparam int ST_LINE_BIT     = 1;
    localparam int ST_PENDING_BIT  = 2;
    localparam int ST_GROUND_BIT   = 3;
    localparam int ST_POR_BIT      = 4;
    localparam int ST_RESET_BIT    = 5;
    localparam int ST_COUNT_LSB    = 8;

endpackage

// >>> core/dac_update_sequencer.sv
// Update and sequencing core of a 40-channel DAC: command queue, computed
// word calculation, open-drain busy line, load strobe and reset sequences.
// Assumes APB master on clk_in; pins arrive asynchronous and are synchronised.
//
// Notes on behaviour
// - Any input, offset or gain write recomputes the channel; busy held low meanwhile.
// - Writes still accepted while busy; no output update while busy.
// - Load strobe falling during busy is stored and done when busy rises.
// - Load strobe held low updates outputs every time busy rises.
// - One-channel write frees busy within 530 ns (queue on) or 330 ns (off).
// - All-channel write frees busy within 5500 ns (queue on) or 5300 ns (off).
// - Load copies only channels rewritten since the previous load.
// - Two loading modes, queue on or off; queue on accepts writes while executing.
// - Queue holds 128 commands; writes arriving when full are dropped silently.
// - Busy is open-drain shared; anyone pulling it low postpones updates.
// - With shared busy, pending update fires once the last device releases it.
// - Power-on clears, restores defaults and holds busy low about 8 ms.
// - During power-on outputs sit at ground reference and command writes are ignored.
// - Load strobe changes are ignored during power-on.
// - Busy rising ends power-on; outputs stay grounded until a load.
// - Reset pin restores all words, busy low for 70 to 120 us.
// - While reset pin low, load ignored, outputs grounded until a later load.
// - Special write with all data ones acts as a soft reset.
// - Special destination writes are increment/decrement on addressed channels.
// - Step size comes from the low seven data bits, zero allowed.
// - Data bit eight picks direction: one adds, zero subtracts.
// - Increment/decrement saturates at full or zero scale.
// - Destination 11 input, 10 offset, 01 gain, 00 special function.
// - Computed word is input*(gain+1)/2^14 + offset - 2^13, clamped.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module dac_update_sequencer
    import dac_seq_pkg::*;
#(
    parameter int POR_COUNT = POR_CYCLES,
    parameter int RST_COUNT = RST_CYCLES
) (
    // Clock, reset, enable
    input  wire logic                    clk_in,
    input  wire logic                    srst_in,
    input  wire logic                    clk_en_in,
    // APB slave
    input  wire logic                    psel_in,
    input  wire logic                    penable_in,
    input  wire logic                    pwrite_in,
    input  wire logic [7:0]              paddr_in,
    input  wire logic [31:0]             pwdata_in,
    output logic                         pready_out,
    output logic                         pslverr_out,
    output logic [31:0]                  prdata_out,
    // Device pins
    input  wire logic                    load_outputs_n_in,
    input  wire logic                    reset_n_in,
    input  wire logic                    busy_n_in,
    output logic                         busy_n_out,
    output logic                         busy_n_oe_out,
    // Converter side
    output logic                         output_ground_ref_out,
    output logic [NUM_CHANNELS-1:0][13:0] analog_outputs_out
);

    // ==========================================================
    // Helper functions
    function automatic logic [13:0] calc_word(input logic [13:0] x1,
                                              input logic [12:0] m,
                                              input logic [13:0] c);
        logic [27:0] prod;
        logic [16:0] sum;
        prod = x1 * ({1'b0, m} + 14'h0001);
        sum  = {3'h0, prod[27:14]} + {3'h0, c} - OFFSET_MID;
        if (sum[16])
            return 14'h0000;
        else if (sum > {3'h0, FULL_SCALE})
            return FULL_SCALE;
        else
            return sum[13:0];
    endfunction

    // Address 0000xxxx selects every channel; else group mask plus index
    function automatic logic chan_hit(input logic [7:0] a, input logic [5:0] ch);
        logic       hit;
        logic [5:0] base;
        hit = (a[7:4] == 4'h0);
        for (int g = 0; g < NUM_GROUPS; g++) begin
            base = 6'(g * GROUP_SIZE);
            if (a[4+g] && ch >= base && ch < base + 6'(GROUP_SIZE) && {2'b00, a[3:0]} == ch - base)
                hit = 1'b1;
        end
        return hit;
    endfunction

    function automatic logic [13:0] step_word(input logic [13:0] x1, input logic [13:0] d);
        logic [14:0] s;
        logic [6:0]  step;
        step = d[STEP_LSB +: STEP_WIDTH];
        s    = {1'b0, x1} + {8'h00, step};
        if (d[STEP_DIR_BIT])
            return (s > {1'b0, FULL_SCALE}) ? FULL_SCALE : s[13:0];
        else
            return (x1 < {7'h00, step}) ? 14'h0000 : x1 - {7'h00, step};
    endfunction

    // ==========================================================
    // Pin synchronisers
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic       load_prev_r;
    logic       load_low;
    logic       load_fall;
    logic       rst_pin_low;
    logic       line_high;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pin_meta_r  <= 3'h7;
            pin_sync_r  <= 3'h7;
            load_prev_r <= 1'b1;
        end else if (clk_en_in) begin
            pin_meta_r  <= {busy_n_in, reset_n_in, load_outputs_n_in};
            pin_sync_r  <= pin_meta_r;
            load_prev_r <= pin_sync_r[0];
        end
    end

    assign load_low    = ~pin_sync_r[0];
    assign load_fall   = load_prev_r & ~pin_sync_r[0];
    assign rst_pin_low = ~pin_sync_r[1];
    assign line_high   = pin_sync_r[2];

    // ==========================================================
    // Sequencer state
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_POR   = 2'b01,
        ST_RESET = 2'b10,
        ST_CALC  = 2'b11
    } seq_state_t;

    seq_state_t       state_r;
    cmd_t             cur_cmd_r;
    logic [5:0]       ch_idx_r;
    logic [31:0]      seq_cnt_r;
    logic             fifo_en_r;
    logic [5:0]       chan_sel_r;
    logic             busy_int;
    logic             restore;

    // Queue storage and pointers
    cmd_t             fifo_mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wr_ptr_r;
    logic [FIFO_AW-1:0] rd_ptr_r;
    logic [FIFO_AW:0]   fifo_cnt_r;
    logic             fifo_full;
    logic             push;
    logic             pop;

    // Bus decode
    logic             apb_access;
    logic             apb_wr;
    logic             addr_ok;

    assign apb_access = psel_in & penable_in & clk_en_in;
    assign apb_wr     = apb_access & pwrite_in;
    assign addr_ok    = paddr_in == REG_CMD || paddr_in == REG_CTRL || paddr_in == REG_STATUS
                     || paddr_in == REG_CHAN_SEL || paddr_in == REG_CHAN_DATA;

    // Queue off behaves as a single-entry holding slot
    assign fifo_full  = fifo_en_r ? (fifo_cnt_r == (FIFO_AW+1)'(FIFO_DEPTH))
                                  : (fifo_cnt_r != '0);
    // Full queue and power-on both drop the write without an error
    assign push       = apb_wr && paddr_in == REG_CMD && !fifo_full
                     && state_r != ST_POR;
    assign pop        = state_r == ST_IDLE && fifo_cnt_r != '0;
    assign busy_int   = state_r != ST_IDLE || fifo_cnt_r != '0;

    always_ff @(posedge clk_in) begin
        if (clk_en_in && push)
            fifo_mem[wr_ptr_r] <= cmd_t'(pwdata_in[23:0]);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || restore) begin
            wr_ptr_r   <= '0;
            rd_ptr_r   <= '0;
            fifo_cnt_r <= '0;
        end else if (clk_en_in) begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            fifo_cnt_r <= fifo_cnt_r + (FIFO_AW+1)'(push) - (FIFO_AW+1)'(pop);
        end
    end

    // ==========================================================
    // Command sequencer
    logic is_soft_reset;

    assign is_soft_reset = fifo_mem[rd_ptr_r].dest_select == DEST_SPECIAL
                        && fifo_mem[rd_ptr_r].write_data_bus == SOFT_RESET_CODE;
    // Defaults restored once at entry to a reset sequence
    assign restore = clk_en_in && ((state_r != ST_RESET && rst_pin_low)
                  || (pop && is_soft_reset));

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r   <= ST_POR;
            cur_cmd_r <= '0;
            ch_idx_r  <= '0;
            seq_cnt_r <= '0;
        end else if (clk_en_in) begin
            case (state_r)
                ST_POR: begin
                    seq_cnt_r <= seq_cnt_r + 1;
                    if (seq_cnt_r >= 32'(POR_COUNT - 1))
                        state_r <= ST_IDLE;
                end
                ST_RESET: begin
                    if (seq_cnt_r < 32'(RST_COUNT))
                        seq_cnt_r <= seq_cnt_r + 1;
                    if (rst_pin_low)
                        seq_cnt_r <= '0;
                    else if (seq_cnt_r >= 32'(RST_COUNT - 1))
                        state_r <= ST_IDLE;
                end
                ST_CALC: begin
                    ch_idx_r <= ch_idx_r + 6'h01;
                    if (ch_idx_r == 6'(NUM_CHANNELS - 1))
                        state_r <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (pop) begin
                        cur_cmd_r <= fifo_mem[rd_ptr_r];
                        ch_idx_r  <= '0;
                        seq_cnt_r <= '0;
                        state_r   <= is_soft_reset ? ST_RESET : ST_CALC;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
            if (rst_pin_low && state_r != ST_POR) begin
                state_r   <= ST_RESET;
                seq_cnt_r <= '0;
            end
        end
    end

    // ==========================================================
    // Channel word storage and recalculation
    logic [13:0] input_word_r    [NUM_CHANNELS];
    logic [13:0] offset_r        [NUM_CHANNELS];
    logic [12:0] gain_r          [NUM_CHANNELS];
    logic [13:0] computed_word_r [NUM_CHANNELS];
    logic        ch_write;
    logic [13:0] new_x1;
    logic [13:0] new_c;
    logic [12:0] new_m;

    assign ch_write = state_r == ST_CALC && chan_hit(cur_cmd_r.channel_select_bus, ch_idx_r);

    always_comb begin
        new_x1 = input_word_r[ch_idx_r];
        new_c  = offset_r[ch_idx_r];
        new_m  = gain_r[ch_idx_r];
        case (cur_cmd_r.dest_select)
            DEST_INPUT:   new_x1 = cur_cmd_r.write_data_bus;
            DEST_OFFSET:  new_c  = cur_cmd_r.write_data_bus;
            DEST_GAIN:    new_m  = cur_cmd_r.write_data_bus[12:0];
            DEST_SPECIAL: new_x1 = step_word(input_word_r[ch_idx_r], cur_cmd_r.write_data_bus);
            default:      new_x1 = input_word_r[ch_idx_r];
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || restore) begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                input_word_r[i]    <= INPUT_DEFAULT;
                offset_r[i]        <= OFFSET_DEFAULT;
                gain_r[i]          <= GAIN_DEFAULT;
                computed_word_r[i] <= COMPUTED_DEFAULT;
            end
        end else if (clk_en_in && ch_write) begin
            input_word_r[ch_idx_r]    <= new_x1;
            offset_r[ch_idx_r]        <= new_c;
            gain_r[ch_idx_r]          <= new_m;
            computed_word_r[ch_idx_r] <= calc_word(new_x1, new_m, new_c);
        end
    end

    // ==========================================================
    // Load strobe handling and output update
    logic                    load_pending_r;
    logic                    load_ignore;
    logic                    load_fire;
    logic [NUM_CHANNELS-1:0] changed_r;
    logic                    grounded_r;
    logic                    busy_oe_r;

    assign load_ignore = state_r == ST_POR || rst_pin_low;
    // Wait for the shared line too, so any other device can hold off the update
    assign load_fire   = !load_ignore && (load_pending_r || load_low)
                      && !busy_int && line_high;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            load_pending_r <= 1'b0;
        end else if (clk_en_in) begin
            if (load_ignore || load_fire)
                load_pending_r <= 1'b0;
            else if (load_fall)
                load_pending_r <= 1'b1;
        end
    end

    // Set wins over clear; a set never meets a fire since fire needs idle
    always_ff @(posedge clk_in) begin
        if (srst_in || restore) begin
            changed_r <= '0;
        end else if (clk_en_in) begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                if (ch_write && ch_idx_r == 6'(i))
                    changed_r[i] <= 1'b1;
                else if (load_fire)
                    changed_r[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            for (int i = 0; i < NUM_CHANNELS; i++)
                analog_outputs_out[i] <= COMPUTED_DEFAULT;
        end else if (clk_en_in && load_fire) begin
            for (int i = 0; i < NUM_CHANNELS; i++)
                if (changed_r[i])
                    analog_outputs_out[i] <= computed_word_r[i];
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            grounded_r <= 1'b1;
        end else if (clk_en_in) begin
            if (rst_pin_low || restore)
                grounded_r <= 1'b1;
            else if (load_fire)
                grounded_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in)
            busy_oe_r <= 1'b1;
        else if (clk_en_in)
            busy_oe_r <= busy_int;
    end

    // Open drain: only ever pulls low
    assign busy_n_out            = 1'b0;
    assign busy_n_oe_out         = busy_oe_r;
    assign output_ground_ref_out = grounded_r;

    // ==========================================================
    // Configuration registers
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            fifo_en_r  <= CTRL_FIFO_EN_RESET;
            chan_sel_r <= '0;
        end else if (apb_wr) begin
            if (paddr_in == REG_CTRL)
                fifo_en_r <= pwdata_in[CTRL_FIFO_EN_BIT];
            if (paddr_in == REG_CHAN_SEL)
                chan_sel_r <= pwdata_in[5:0];
        end
    end

    // ==========================================================
    // APB read path; zero wait states while enabled
    logic [5:0] rd_chan;

    assign rd_chan     = (chan_sel_r < 6'(NUM_CHANNELS)) ? chan_sel_r : 6'h00;
    assign pready_out  = clk_en_in;
    assign pslverr_out = psel_in & penable_in & ~addr_ok;

    always_comb begin
        prdata_out = '0;
        case (paddr_in)
            REG_CTRL:      prdata_out[CTRL_FIFO_EN_BIT] = fifo_en_r;
            REG_CHAN_SEL:  prdata_out[5:0] = chan_sel_r;
            REG_CHAN_DATA: prdata_out = {2'h0, computed_word_r[rd_chan], 2'h0, analog_outputs_out[rd_chan]};
            REG_STATUS: begin
                prdata_out[ST_BUSY_BIT]    = busy_int;
                prdata_out[ST_LINE_BIT]    = line_high;
                prdata_out[ST_PENDING_BIT] = load_pending_r;
                prdata_out[ST_GROUND_BIT]  = grounded_r;
                prdata_out[ST_POR_BIT]     = state_r == ST_POR;
                prdata_out[ST_RESET_BIT]   = state_r == ST_RESET;
                prdata_out[ST_COUNT_LSB +: FIFO_AW+1] = fifo_cnt_r;
            end
            default:       prdata_out = '0;
        endcase
    end

endmodule

`default_nettype wire

// >>> verif/dac_seq_asserts.sv
// Checker on sequencer ports: busy, ground, outputs.
// Assumes it is bound onto every sequencer instance; one clock.
`timescale 1ns/1ps
`default_nettype none
module dac_seq_asserts
    import dac_seq_pkg::*;
(
    // Clock and reset
    input wire logic                          clk_in,
    input wire logic                          srst_in,
    // Bus, pins and outputs
    input wire logic                          psel_in,
    input wire logic                          penable_in,
    input wire logic [7:0]                    paddr_in,
    input wire logic                          pslverr_out,
    input wire logic                          reset_n_in,
    input wire logic                          busy_n_in,
    input wire logic                          busy_n_oe_out,
    input wire logic                          output_ground_ref_out,
    input wire logic [NUM_CHANNELS-1:0][13:0] analog_outputs_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    // ==========================================================
    // Sequences and update gating
    por_hold_a: assert property ($fell(srst_in) |-> (output_ground_ref_out && busy_n_oe_out)[*8])
        else $error("power-on hold short");
    reset_hold_a: assert property ((!reset_n_in)[*5] |-> busy_n_oe_out && output_ground_ref_out)
        else $error("reset pin not grounding");
    reset_len_a: assert property ((!reset_n_in)[*5] ##1 reset_n_in |-> busy_n_oe_out[*8])
        else $error("reset busy too short");
    // Grounded cycles excluded: outputs sit at ground reference then
    busy_freeze_a: assert property (busy_n_oe_out && $past(busy_n_oe_out) && !output_ground_ref_out
        |-> $stable(analog_outputs_out)) else $error("update while busy");
    wire_freeze_a: assert property ((!busy_n_in)[*3] |=> $stable(analog_outputs_out) || output_ground_ref_out)
        else $error("wire low update");
    load_ignored_a: assert property (output_ground_ref_out ##1 busy_n_oe_out |-> output_ground_ref_out)
        else $error("load taken while busy");
    update_idle_a: assert property ($fell(output_ground_ref_out)
        |-> !busy_n_oe_out && ($past(busy_n_in, 2) || $past(busy_n_in, 3))) else $error("update before release");
    cmd_no_err_a: assert property (psel_in && penable_in && paddr_in == REG_CMD |-> !pslverr_out)
        else $error("command write flagged");
    cover property ($fell(output_ground_ref_out));
    cover property (!busy_n_in && !busy_n_oe_out);
    cover property ($fell(busy_n_oe_out));
endmodule
bind dac_update_sequencer dac_seq_asserts chk (.clk_in, .srst_in, .psel_in, .penable_in, .paddr_in, .pslverr_out,
    .reset_n_in, .busy_n_in, .busy_n_oe_out, .output_ground_ref_out, .analog_outputs_out);
`default_nettype wire

// >>> verif/dac_update_sequencer_bench.sv
// Sequencer bench: APB commands, host pin model.
// Assumes power-on and reset counts shortened to 50 and 20 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module dac_update_sequencer_bench
    import dac_seq_pkg::*;
;
    localparam int          POR_N = 50;
    localparam int          RST_N = 20;
    localparam logic [15:0] STEP_CMD [6] = '{16'hFFF0, 16'h017F, 16'h007F, 16'hC010, 16'h007F, 16'h0100};
    localparam logic [13:0] STEP_EXP [6] = '{14'h10FC, 14'h10FF, 14'h10E0, 14'h0104, 14'h0100, 14'h0100};
    logic        clk_in = 1'b0, srst_in = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        load_req = 1'b0, reset_req = 1'b0, hold_req = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        pready, pslverr, oe, wire_lvl, load_n, reset_n, ground, drv, err;
    logic [31:0] prdata, rd, pwdata = 32'h0;
    logic [NUM_CHANNELS-1:0][13:0] outs;
    int          error_cnt = 0, n_checks = 0, bw = 0, last_w = 0, k;
    always #2 clk_in = ~clk_in;
    // Last busy pulse width in cycles
    always @(posedge clk_in) begin
        bw <= oe ? bw + 1 : 0;
        if (!oe && bw != 0) last_w <= bw;
    end
    dac_update_sequencer #(.POR_COUNT(POR_N), .RST_COUNT(RST_N)) dut (.clk_in, .srst_in, .clk_en_in(1'b1),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata), .load_outputs_n_in(load_n),
        .reset_n_in(reset_n), .busy_n_in(wire_lvl), .busy_n_out(drv), .busy_n_oe_out(oe),
        .output_ground_ref_out(ground), .analog_outputs_out(outs));
    host_pins_model host (.clk_in, .load_req_in(load_req), .reset_req_in(reset_req), .hold_req_in(hold_req),
        .dut_oe_in(oe), .load_n_out(load_n), .reset_n_out(reset_n), .busy_wire_out(wire_lvl));
    // ==========================================================
    // Bus tasks
    task automatic complete_run();
        if (error_cnt == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk_in) pen <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_in);
            if (pready === 1'b1) break;
        end
        rd = prdata; err = pslverr;
        psel <= 1'b0; pen <= 1'b0;
        @(posedge clk_in);
        if (n == 50) begin error_cnt++; complete_run(); end
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < 3000; n++) begin
            apb(1'b0, REG_STATUS, 32'h0);
            if ({rd[15:8], rd[ST_RESET_BIT], rd[ST_POR_BIT], rd[ST_BUSY_BIT]} === 11'h000) break;
        end
        repeat (6) @(posedge clk_in);
        if (n == 3000) begin error_cnt++; complete_run(); end
    endtask
    function automatic logic [31:0] cmd(dest_t s, logic [7:0] c, logic [13:0] d);
        return {8'h00, s, c, d};
    endfunction
    task automatic chan0();
        apb(1'b1, REG_CHAN_SEL, 32'h0);
        apb(1'b0, REG_CHAN_DATA, 32'h0);
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        srst_in <= 1'b0;
        apb(1'b1, REG_CMD, cmd(DEST_INPUT, 8'h10, 14'h1234));
        wait_idle();
        `CHECK("por busy", 1'b1, last_w >= POR_N + 6 && last_w <= POR_N + 12)
        `CHECK("por ground", 1'b1, ground)
        chan0();
        `CHECK("por write", COMPUTED_DEFAULT, rd[29:16])
        apb(1'b1, REG_CMD, cmd(DEST_OFFSET, 8'h10, 14'h2100));
        apb(1'b1, REG_CMD, cmd(DEST_GAIN, 8'h10, 14'h0FFF));
        wait_idle();
        apb(1'b1, REG_CMD, cmd(DEST_INPUT, 8'h10, 14'h1000));
        wait_idle();
        `CHECK("busy 1ch", 1'b1, last_w * CLK_PERIOD_NS <= 530)
        chan0();
        `CHECK("computed", 14'h0500, rd[29:16])
        `CHECK("out held", 14'h2000, outs[0])
        hold_req <= 1'b1;
        load_req <= 1'b1;
        repeat (4) @(posedge clk_in);
        load_req <= 1'b0;
        repeat (10) @(posedge clk_in);
        `CHECK("wire hold", 1'b1, ground)
        hold_req <= 1'b0;
        for (k = 0; k < 20 && ground !== 1'b0; k++) @(posedge clk_in);
        `CHECK("stored load", 14'h0500, outs[0])
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, REG_CMD, cmd(dest_t'(STEP_CMD[i][15:14]), 8'h10, STEP_CMD[i][13:0]));
            wait_idle();
            chan0();
            `CHECK("step", STEP_EXP[i], rd[29:16])
        end
        load_req <= 1'b1;
        apb(1'b1, REG_CMD, cmd(DEST_INPUT, 8'h10, 14'h2000));
        wait_idle();
        for (k = 0; k < 20 && outs[0] !== 14'h0900; k++) @(posedge clk_in);
        `CHECK("held load", 14'h0900, outs[0])
        load_req <= 1'b0;
        for (int i = 0; i < 150; i++) apb(1'b1, REG_CMD, cmd(DEST_INPUT, 8'h11, 14'(i)));
        apb(1'b0, REG_STATUS, 32'h0);
        `CHECK("queue cap", 1'b1, rd[15:8] >= 8'h7F && rd[15:8] <= 8'h80)
        wait_idle();
        apb(1'b1, REG_CTRL, 32'h0);
        apb(1'b0, REG_CTRL, 32'h0);
        `CHECK("queue off", 1'b0, rd[CTRL_FIFO_EN_BIT])
        apb(1'b1, REG_CMD, cmd(DEST_INPUT, 8'h12, 14'h0100));
        wait_idle();
        `CHECK("busy 1ch off", 1'b1, last_w * CLK_PERIOD_NS <= 330)
        apb(1'b1, REG_CMD, cmd(DEST_INPUT, 8'h00, 14'h0100));
        wait_idle();
        `CHECK("busy all", 1'b1, last_w * CLK_PERIOD_NS <= 5300)
        load_req <= 1'b1;
        reset_req <= 1'b1;
        repeat (10) @(posedge clk_in);
        reset_req <= 1'b0;
        load_req <= 1'b0;
        wait_idle();
        `CHECK("reset busy", 1'b1, last_w >= RST_N && last_w <= RST_N * 120 / 70 + 12)
        `CHECK("reset ground", 1'b1, ground)
        apb(1'b1, REG_CMD, cmd(DEST_INPUT, 8'h10, 14'h3000));
        wait_idle();
        chan0();
        `CHECK("pre soft", 14'h1800, rd[29:16])
        apb(1'b1, REG_CMD, cmd(DEST_SPECIAL, 8'h00, SOFT_RESET_CODE));
        wait_idle();
        chan0();
        `CHECK("soft reset", COMPUTED_DEFAULT, rd[29:16])
        apb(1'b0, 8'h40, 32'h0);
        `CHECK("unmapped", 1'b1, err)
        `CHECK("busy drive", 1'b0, drv)
        complete_run();
    end
endmodule
`default_nettype wire

// >>> verif/host_pins_model.sv
// Host pin model: load strobe, reset pin and a second busy puller.
// Assumes bench requests; busy wire pulled up.
`timescale 1ns/1ps
`default_nettype none
module host_pins_model (
    // Clock and requests
    input  wire logic clk_in,
    input  wire logic load_req_in,
    input  wire logic reset_req_in,
    input  wire logic hold_req_in,
    input  wire logic dut_oe_in,
    // Pins
    output logic      load_n_out = 1'b1,
    output logic      reset_n_out = 1'b1,
    output wire logic busy_wire_out
);
    // ==========================================================
    // Pins move just after an edge
    always @(posedge clk_in) begin
        load_n_out <= !load_req_in;
        reset_n_out <= !reset_req_in;
    end
    // Any puller wins over the pull-up
    assign busy_wire_out = !(dut_oe_in || hold_req_in);
endmodule
`default_nettype wire
